// [core/tape_reader_step_alarm_ctrl.sv]
// reader stop, step-read, manual step and alarm latch control
//
// Operation
// (R01) stop switch passes a set/reset latch so chatter gives one level change
// (R02) reader stop goes out only while stop switch in stop and on-line
// (R03) single-advance latch sets on step-read switch rise while reader stop asserted
// (R04) master withholds header generator and reader steps while reader stop asserted
// (R05) single-advance latch goes out as a one-cycle step-read pulse
// (R06) stop switch back to normal: reader follows the master's step pulses again
// (R07) manual step debounced, blocked when stop normal and on-line, else one pulse
// (R08) manual and master step pulses merge onto one reader driver output
// (R09) stop, on-line and manual step together raise an alarm suppress indication
// (R10) stop and step-read outputs held inactive for 80 ms after power-on
// (R11) separate verify and feed error alarm latches, each set by its input
// (R12) alarm latches set only while on-line; off-line errors ignored
// (R13) set alarm lights its lamp and signals the master verifier
// (R14) alarm present at power-up is gated off the master output; here only during the hold, it is sent to the master once released
// (R15) master stops all other senders on any sender's alarm
// (R16) alarm clear switch resets both latches and their lamps
// (R17) on-line lamp lit whenever on-line is received
// (R18) alarm output isolated during power-up like stop and step-read
// (R19) switch and master inputs synchronised, register port used directly; transition actions are one-cycle edge detects
// (R20) power-on hold clears control latches so nothing reaches the master at turn-on; alarm latches still set during hold, only the outputs are gated
`include "trsa_defines.svh"

module tape_reader_step_alarm_ctrl
    import trsa_pkg::*;
#(
    parameter int HOLD_CYC = `TRSA_HOLD_CYC
)
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [`TRSA_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output trsa_word_t regRdata,
    // operator switches, make and break contacts
    input wire logic [`TRSA_NUM_SW-1:0] swMake,
    input wire logic [`TRSA_NUM_SW-1:0] swBreak,
    // from the master cabinet
    input wire logic onLine,
    input wire logic seqStep,
    input wire logic verifyErr,
    input wire logic feedErr,
    // to the master cabinet and reader driver
    output logic readerStop,
    output logic stepRead,
    output logic readerDrive,
    output logic alarmSuppress,
    output logic alarmToMaster,
    // lamps
    output logic stopLamp,
    output logic onLineLamp,
    output logic verifyLamp,
    output logic feedLamp
);
    localparam logic [`TRSA_HOLD_W-1:0] HOLD_LAST = `TRSA_HOLD_W'(HOLD_CYC - 1);

    trsa_sw_if swIf [`TRSA_NUM_SW] ();

    genvar gi;
    generate
        for (gi = 0; gi < `TRSA_NUM_SW; gi++)
        begin : g_sw
            trsa_sw_debounce u_deb
            (
                .clock(clock),
                .nrst(nrst),
                .contactMake(swMake[gi]),
                .contactBreak(swBreak[gi]),
                .sw(swIf[gi])
            );
        end
    endgenerate

    // master inputs: two-stage synchroniser then edge detect on the second stage
    logic [`TRSA_NUM_M-1:0] mIn, m1_r, m2_r, mPrev_r, mRise;
    assign mIn = {feedErr, verifyErr, seqStep, onLine};
    assign mRise = m2_r & ~mPrev_r; // R19

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            m1_r <= '0;
            m2_r <= '0;
            mPrev_r <= '0;
        end
        else
        begin
            m1_r <= mIn; // R19
            m2_r <= m1_r;
            mPrev_r <= m2_r;
        end
    end

    wire onLineS = m2_r[`TRSA_M_ONLINE];
    wire seqStepS = m2_r[`TRSA_M_SEQSTEP];
    wire verRise = mRise[`TRSA_M_VERERR];
    wire feedRise = mRise[`TRSA_M_FEEDERR];
    wire stopLvl = swIf[`TRSA_SW_STOP].level;
    wire stepReadRise = swIf[`TRSA_SW_STEPREAD].rise;
    wire stepLvl = swIf[`TRSA_SW_STEP].level;
    wire stepRise = swIf[`TRSA_SW_STEP].rise;
    wire clrRise = swIf[`TRSA_SW_CLR].rise;

    // power-on hold: outputs toward the master stay inactive until released
    trsa_pwr_e pwr_r, pwr_nxt;
    logic [`TRSA_HOLD_W-1:0] holdCnt_r, holdCnt_nxt;
    logic released_r;

    always_comb
    begin
        pwr_nxt = pwr_r;
        holdCnt_nxt = holdCnt_r;
        unique case (pwr_r)
            PWR_HOLD:
            begin
                if (holdCnt_r == HOLD_LAST)
                    pwr_nxt = PWR_RUN; // R10
                else
                    holdCnt_nxt = holdCnt_r + `TRSA_HOLD_W'h1;
            end
            PWR_RUN:
                pwr_nxt = PWR_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pwr_r <= PWR_HOLD;
            holdCnt_r <= '0;
            released_r <= 1'b0; // R20
        end
        else
        begin
            pwr_r <= pwr_nxt;
            holdCnt_r <= holdCnt_nxt;
            released_r <= (pwr_nxt == PWR_RUN);
        end
    end

    // register port decode
    wire wrCtrl = regWr && (regAddr == `TRSA_REG_CTRL);
    wire swClr = wrCtrl && regWdata[`TRSA_CTRL_CLR];
    wire rdStat = regRd && (regAddr == `TRSA_REG_STAT);

    // stop, step-read, manual step and suppress
    logic readerStop_r, stepRead_r, readerDrive_r, alarmSuppress_r;
    wire stopNxt = stopLvl & onLineS & released_r; // R02 R10
    wire stepReadNxt = stepReadRise & readerStop_r & released_r; // R03 R05
    wire manualOk = stopLvl | ~onLineS; // R07
    wire manualPulse = stepRise & manualOk; // R07
    // master steps pass straight through; the master itself withholds them while stopped
    wire driveNxt = seqStepS | manualPulse; // R06 R08
    wire suppressNxt = stopLvl & onLineS & stepLvl & released_r; // R09

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            readerStop_r <= 1'b0;
            stepRead_r <= 1'b0;
            readerDrive_r <= 1'b0;
            alarmSuppress_r <= 1'b0;
        end
        else
        begin
            readerStop_r <= stopNxt;
            stepRead_r <= stepReadNxt;
            readerDrive_r <= driveNxt;
            alarmSuppress_r <= suppressNxt;
        end
    end

    // alarm latches: a new error in the clearing cycle wins over the clear
    logic verAlarm_r, feedAlarm_r, alarmOut_r, onLineLamp_r;
    wire clrEvt = clrRise | swClr; // R16
    wire verSet = verRise & onLineS; // R11 R12
    wire feedSet = feedRise & onLineS; // R11 R12
    wire verNxt = verSet | (verAlarm_r & ~clrEvt); // R16
    wire feedNxt = feedSet | (feedAlarm_r & ~clrEvt); // R16
    wire alarmOutNxt = (verNxt | feedNxt) & released_r; // R13 R14 R18

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            verAlarm_r <= 1'b0;
            feedAlarm_r <= 1'b0;
            alarmOut_r <= 1'b0;
            onLineLamp_r <= 1'b0;
        end
        else
        begin
            verAlarm_r <= verNxt;
            feedAlarm_r <= feedNxt;
            alarmOut_r <= alarmOutNxt;
            onLineLamp_r <= onLineS; // R17
        end
    end

    // status read; data stand only in the cycle after the strobe
    trsa_word_t statWord, rdata_r;
    logic stopLamp_r;
    always_comb
    begin
        statWord = '0;
        statWord[`TRSA_ST_STOPSW] = stopLvl;
        statWord[`TRSA_ST_ONLINE] = onLineS;
        statWord[`TRSA_ST_RDSTOP] = readerStop_r;
        statWord[`TRSA_ST_VERALM] = verAlarm_r;
        statWord[`TRSA_ST_FEEDALM] = feedAlarm_r;
        statWord[`TRSA_ST_RELEASED] = released_r;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata_r <= '0;
            stopLamp_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdStat ? statWord : '0;
            stopLamp_r <= stopLvl;
        end
    end

    assign regRdata = rdata_r;
    assign readerStop = readerStop_r;
    assign stepRead = stepRead_r;
    assign readerDrive = readerDrive_r;
    assign alarmSuppress = alarmSuppress_r;
    assign alarmToMaster = alarmOut_r;
    assign stopLamp = stopLamp_r;
    assign onLineLamp = onLineLamp_r;
    assign verifyLamp = verAlarm_r; // R13
    assign feedLamp = feedAlarm_r; // R13

    // checks
    property p_hold_quiet;
        @(posedge clock) disable iff (!nrst)
        !$past(released_r) |-> !readerStop_r && !stepRead_r && !alarmOut_r;
    endproperty
    a_hold_quiet: assert property (p_hold_quiet) // R10 R18
        else $error("output toward master during power-on hold");

    property p_release_time;
        @(posedge clock) disable iff (!nrst)
        $rose(released_r) |-> $past(holdCnt_r) == HOLD_LAST;
    endproperty
    a_release_time: assert property (p_release_time) // R20
        else $error("hold released at wrong count");

    property p_stop_cause;
        @(posedge clock) disable iff (!nrst)
        readerStop_r |-> $past(stopLvl) && $past(onLineS);
    endproperty
    a_stop_cause: assert property (p_stop_cause) // R02
        else $error("reader stop without stop switch and on-line");

    property p_stepread_pulse;
        @(posedge clock) disable iff (!nrst)
        stepRead_r |-> $past(readerStop_r) && $past(stepReadRise) ##1 !stepRead_r;
    endproperty
    a_stepread_pulse: assert property (p_stepread_pulse) // R03 R05
        else $error("step-read pulse without cause or too long");

    property p_manual_block;
        @(posedge clock) disable iff (!nrst)
        (stepRise && !stopLvl && onLineS) |=> readerDrive_r == $past(seqStepS);
    endproperty
    a_manual_block: assert property (p_manual_block) // R07
        else $error("manual step passed while reader on-line and running");

    property p_manual_pass;
        @(posedge clock) disable iff (!nrst)
        (stepRise && (stopLvl || !onLineS)) |=> readerDrive_r;
    endproperty
    a_manual_pass: assert property (p_manual_pass) // R07 R08
        else $error("manual step pulse lost");

    property p_suppress;
        @(posedge clock) disable iff (!nrst)
        $rose(alarmSuppress_r) |-> $past(stepLvl) && $past(stopLvl) && $past(onLineS);
    endproperty
    a_suppress: assert property (p_suppress) // R09
        else $error("alarm suppress without its three conditions");

    property p_alarm_offline;
        @(posedge clock) disable iff (!nrst)
        (!onLineS && !verAlarm_r && !feedAlarm_r) |=> !verAlarm_r && !feedAlarm_r;
    endproperty
    a_alarm_offline: assert property (p_alarm_offline) // R12
        else $error("alarm latched while off-line");

    property p_alarm_set;
        @(posedge clock) disable iff (!nrst)
        (verRise && onLineS) |=> verAlarm_r ##1 (verAlarm_r || $past(clrEvt));
    endproperty
    a_alarm_set: assert property (p_alarm_set) // R11
        else $error("verify error not latched");

    property p_alarm_clear;
        @(posedge clock) disable iff (!nrst)
        (clrEvt && !verSet && !feedSet) |=> !verAlarm_r && !feedAlarm_r && !verifyLamp;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear) // R16
        else $error("alarm clear did not reset latches");

    property p_alarm_out;
        @(posedge clock) disable iff (!nrst)
        ($past(released_r) && (verAlarm_r || feedAlarm_r)) |-> alarmOut_r;
    endproperty
    a_alarm_out: assert property (p_alarm_out) // R13
        else $error("latched alarm not sent to master");

    property p_online_lamp;
        @(posedge clock) disable iff (!nrst)
        onLineS |=> onLineLamp_r;
    endproperty
    a_online_lamp: assert property (p_online_lamp) // R17
        else $error("on-line lamp dark while on-line");

    // the alarm output lags the latch by one cycle at hold release, so the
    // latch is checked here on its own
    property p_feed_set;
        @(posedge clock) disable iff (!nrst)
        (feedRise && onLineS) |=> feedAlarm_r && feedLamp;
    endproperty
    a_feed_set: assert property (p_feed_set) // R11 R13
        else $error("feed error not latched");

    property p_master_step;
        @(posedge clock) disable iff (!nrst)
        seqStepS |=> readerDrive_r;
    endproperty
    a_master_step: assert property (p_master_step) // R06 R08
        else $error("master step pulse not passed to reader driver");
endmodule

// [core/trsa_defines.svh]
// constants of the tape reader step and alarm control
`ifndef TRSA_DEFINES_SVH
`define TRSA_DEFINES_SVH

`define TRSA_CLK_HZ 25000000
`define TRSA_HOLD_MS 80
`define TRSA_HOLD_CYC ((`TRSA_CLK_HZ / 1000) * `TRSA_HOLD_MS)
`define TRSA_HOLD_W 21

`define TRSA_ADDR_W 4
`define TRSA_REG_CTRL 4'h0
`define TRSA_REG_STAT 4'h4
`define TRSA_CTRL_CLR 0

`define TRSA_ST_STOPSW 0
`define TRSA_ST_ONLINE 1
`define TRSA_ST_RDSTOP 2
`define TRSA_ST_VERALM 3
`define TRSA_ST_FEEDALM 4
`define TRSA_ST_RELEASED 5

`define TRSA_NUM_SW 4
`define TRSA_SW_STOP 0
`define TRSA_SW_STEPREAD 1
`define TRSA_SW_STEP 2
`define TRSA_SW_CLR 3

`define TRSA_NUM_M 4
`define TRSA_M_ONLINE 0
`define TRSA_M_SEQSTEP 1
`define TRSA_M_VERERR 2
`define TRSA_M_FEEDERR 3

`endif

// [core/trsa_pkg.sv]
// types of the tape reader step and alarm control
package trsa_pkg;
    typedef enum logic {PWR_HOLD, PWR_RUN} trsa_pwr_e;
    typedef logic [31:0] trsa_word_t;
endpackage

// [core/trsa_sw_debounce.sv]
// two-contact switch synchroniser, set/reset latch and edge detect
module trsa_sw_debounce
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // switch contacts
    input wire logic contactMake,
    input wire logic contactBreak,
    // clean switch
    trsa_sw_if.src sw
);
    logic mk1_r, mk2_r, bk1_r, bk2_r;
    logic latch_r, latch_nxt, rise_r;

    // set/reset latch: chatter on one contact cannot flip it back
    assign latch_nxt = (mk2_r & ~bk2_r) ? 1'b1 :
                       (bk2_r & ~mk2_r) ? 1'b0 : latch_r; // R01

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mk1_r <= 1'b0;
            mk2_r <= 1'b0;
            bk1_r <= 1'b0;
            bk2_r <= 1'b0;
            latch_r <= 1'b0;
            rise_r <= 1'b0;
        end
        else
        begin
            mk1_r <= contactMake; // R19
            mk2_r <= mk1_r;
            bk1_r <= contactBreak;
            bk2_r <= bk1_r;
            latch_r <= latch_nxt;
            rise_r <= latch_nxt & ~latch_r; // R19
        end
    end

    assign sw.level = latch_r;
    assign sw.rise = rise_r;
endmodule

// [core/trsa_sw_if.sv]
// debounced switch level and its rising edge
interface trsa_sw_if;
    logic level;
    logic rise;
    modport src (output level, output rise);
    modport snk (input level, input rise);
endinterface

// [verification/tape_reader_step_alarm_ctrl_bench.sv]
// self-checking bench of the tape reader step and alarm control
`include "trsa_defines.svh"

module tape_reader_step_alarm_ctrl_bench
    import trsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    trsa_word_t regRdata;
    logic [3:0] swMake = 4'h1;
    logic [3:0] swBreak = 4'he;
    logic goOnline = 1'b1;
    logic stepReq = 1'b0;
    logic verReq = 1'b0;
    logic feedReq = 1'b0;
    logic onLine, seqStep, verifyErr, feedErr;
    logic readerStop, stepRead, readerDrive, alarmSuppress, alarmToMaster;
    logic stopLamp, onLineLamp, verifyLamp, feedLamp;
    logic prevStep = 1'b0;
    logic prevDrive = 1'b0;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int stepRise = 0;
    int stepHigh = 0;
    int driveRise = 0;

    // short hold keeps the run brief; real value is 80 ms of cycles
    tape_reader_step_alarm_ctrl #(.HOLD_CYC(20)) dut (.clock(clock), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .swMake(swMake), .swBreak(swBreak), .onLine(onLine),
        .seqStep(seqStep), .verifyErr(verifyErr), .feedErr(feedErr),
        .readerStop(readerStop), .stepRead(stepRead), .readerDrive(readerDrive),
        .alarmSuppress(alarmSuppress), .alarmToMaster(alarmToMaster),
        .stopLamp(stopLamp), .onLineLamp(onLineLamp), .verifyLamp(verifyLamp),
        .feedLamp(feedLamp));

    trsa_master_model master (.clock(clock), .nrst(nrst), .goOnline(goOnline),
        .stepReq(stepReq), .verReq(verReq), .feedReq(feedReq),
        .readerStop(readerStop), .alarmToMaster(alarmToMaster), .onLine(onLine),
        .seqStep(seqStep), .verifyErr(verifyErr), .feedErr(feedErr));

    initial
    begin
        forever #20 clock = ~clock;
    end

    always @(posedge clock)
    begin
        prevStep <= stepRead;
        prevDrive <= readerDrive;
        if (stepRead === 1'b1)
            stepHigh++;
        if (stepRead === 1'b1 && prevStep === 1'b0)
            stepRise++;
        if (readerDrive === 1'b1 && prevDrive === 1'b0)
            driveRise++;
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic sw(input int i, input logic on);
        @(posedge clock);
        swMake[i] <= on;
        swBreak[i] <= ~on;
    endtask

    // make contact bounces open once; the latch must hold through it
    task automatic press(input int i);
        sw(i, 1'b1);
        @(posedge clock);
        swMake[i] <= 1'b0;
        @(posedge clock);
        swMake[i] <= 1'b1;
        cyc(6);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic t_power_hold;
        logic [31:0] d;
        cyc(4);
        @(posedge clock);
        verReq <= 1'b1;
        @(posedge clock);
        verReq <= 1'b0;
        cyc(6);
        check(verifyLamp, 1'b1);
        check(alarmToMaster, 1'b0);
        check(readerStop, 1'b0);
        reg_rd(`TRSA_REG_STAT, d);
        check(d, 32'h0000000b);
        cyc(12);
        check(alarmToMaster, 1'b1);
        check(readerStop, 1'b1);
        reg_rd(`TRSA_REG_STAT, d);
        check(d, 32'h0000002f);
        reg_rd(4'h8, d);
        check(d, 32'h0);
        reg_wr(`TRSA_REG_CTRL, 32'h1);
        cyc(3);
        check({verifyLamp, alarmToMaster}, 2'b00);
    endtask

    task automatic t_step_read;
        int s0, h0, d0;
        s0 = stepRise;
        h0 = stepHigh;
        d0 = driveRise;
        press(`TRSA_SW_STEPREAD);
        sw(`TRSA_SW_STEPREAD, 1'b0);
        cyc(6);
        check(stepRise - s0, 1);
        check(stepHigh - h0, 1);
        press(`TRSA_SW_STEP);
        check(alarmSuppress, 1'b1);
        sw(`TRSA_SW_STEP, 1'b0);
        cyc(6);
        check(driveRise - d0, 1);
        sw(`TRSA_SW_STOP, 1'b0);
        cyc(6);
        check({readerStop, stopLamp}, 2'b00);
        press(`TRSA_SW_STEPREAD);
        sw(`TRSA_SW_STEPREAD, 1'b0);
        cyc(6);
        check(stepRise - s0, 1);
    endtask

    task automatic t_manual;
        int d0;
        d0 = driveRise;
        press(`TRSA_SW_STEP);
        check(alarmSuppress, 1'b0);
        sw(`TRSA_SW_STEP, 1'b0);
        cyc(6);
        check(driveRise - d0, 0);
        @(posedge clock);
        stepReq <= 1'b1;
        cyc(12);
        @(posedge clock);
        stepReq <= 1'b0;
        cyc(6);
        check(driveRise > d0 + 3, 1'b1);
        d0 = driveRise;
        @(posedge clock);
        goOnline <= 1'b0;
        cyc(6);
        check(onLineLamp, 1'b0);
        press(`TRSA_SW_STEP);
        sw(`TRSA_SW_STEP, 1'b0);
        cyc(6);
        check(driveRise - d0, 1);
    endtask

    task automatic t_alarms;
        @(posedge clock);
        verReq <= 1'b1;
        feedReq <= 1'b1;
        @(posedge clock);
        verReq <= 1'b0;
        feedReq <= 1'b0;
        cyc(6);
        check({verifyLamp, feedLamp}, 2'b00);
        @(posedge clock);
        goOnline <= 1'b1;
        cyc(6);
        check(onLineLamp, 1'b1);
        @(posedge clock);
        verReq <= 1'b1;
        feedReq <= 1'b1;
        @(posedge clock);
        verReq <= 1'b0;
        feedReq <= 1'b0;
        cyc(6);
        check({verifyLamp, feedLamp, alarmToMaster}, 3'b111);
        press(`TRSA_SW_CLR);
        sw(`TRSA_SW_CLR, 1'b0);
        cyc(4);
        check({verifyLamp, feedLamp, alarmToMaster}, 3'b000);
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        t_power_hold();
        t_step_read();
        t_manual();
        t_alarms();
        print_verdict();
    end
endmodule

// [verification/trsa_master_model.sv]
// behavioural model of the master cabinet sequence control and verifier
module trsa_master_model
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // bench controls
    input wire logic goOnline,
    input wire logic stepReq,
    input wire logic verReq,
    input wire logic feedReq,
    // from the reader control
    input wire logic readerStop,
    input wire logic alarmToMaster,
    // to the reader control
    output logic onLine,
    output logic seqStep,
    output logic verifyErr,
    output logic feedErr
);
    timeunit 1ns;
    timeprecision 1ns;

    // a real master gates its step train, it never trusts the sender to do it
    logic stepOk;
    assign stepOk = stepReq & ~readerStop & ~alarmToMaster;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            onLine <= 1'b0;
            seqStep <= 1'b0;
            verifyErr <= 1'b0;
            feedErr <= 1'b0;
        end
        else
        begin
            onLine <= goOnline;
            seqStep <= stepOk & ~seqStep;
            verifyErr <= verReq;
            feedErr <= feedReq;
        end
    end
endmodule
